/* src/slm_pkg.sv */
// Package: constants and types for the supply low monitor
package slm_pkg;

  // Special-function register map
  localparam logic [7:0] SLM_CTRL_ADDR = 8'hdf;
  localparam logic [7:0] SLM_CTRL_RESET = 8'hde;

  // Field positions in supply_monitor_control
  localparam int SLM_BIT_DCMP = 7;
  localparam int SLM_BIT_ACMP = 6;
  localparam int SLM_BIT_FLAG = 5;
  localparam int SLM_BIT_DTRIP_HI = 4;
  localparam int SLM_BIT_DTRIP_LO = 3;
  localparam int SLM_BIT_ATRIP_HI = 2;
  localparam int SLM_BIT_ATRIP_LO = 1;
  localparam int SLM_BIT_ON = 0;

  // Trip select codes
  localparam logic [1:0] SLM_TRIP_4V63 = 2'h0;
  localparam logic [1:0] SLM_TRIP_3V08 = 2'h1;
  localparam logic [1:0] SLM_TRIP_2V93 = 2'h2;
  localparam logic [1:0] SLM_TRIP_2V63 = 2'h3;

  // Timing
  localparam longint SLM_CLK_HZ = 200000000;
  localparam longint SLM_HOLD_MS = 250;
  localparam longint SLM_HOLD_CYCLES = (SLM_CLK_HZ * SLM_HOLD_MS) / 1000;
  localparam int SLM_GLITCH_CYCLES = 8;
  localparam int SLM_GLITCH_W = 4;
  localparam int SLM_HOLD_W = 26;

  // Filter state
  typedef struct packed {
    logic [1:0] stable;
    logic [1:0][SLM_GLITCH_W-1:0] cnt;
  } slm_filt_s;

  // Top state
  typedef struct packed {
    logic [1:0] dtrip;
    logic [1:0] atrip;
    logic on;
    logic flag;
    logic [SLM_HOLD_W-1:0] hold;
    logic [7:0] rdata;
  } slm_top_s;

endpackage : slm_pkg

/* src/slm_cmp_if.sv */
// Interface: raw and filtered comparator levels
`timescale 1ns/1ps
interface slm_cmp_if;
  logic [1:0] raw;
  logic [1:0] clean;
  modport filt (input raw, output clean);
  modport core (output raw, input clean);
endinterface : slm_cmp_if

/* src/slm_glitch_filter.sv */
// Module: glitch filter on the two comparator outputs
`timescale 1ns/1ps
module slm_glitch_filter import slm_pkg::*; #(
  parameter int FILT_CYCLES = SLM_GLITCH_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Comparator levels
  slm_cmp_if.filt cmp
);

  slm_filt_s r;
  slm_filt_s next_r;

  always_comb begin
    next_r = r;
    for (int i = 0; i < 2; i++) begin
      if (cmp.raw[i] == r.stable[i]) begin
        next_r.cnt[i] = '0;
      end else if (r.cnt[i] == SLM_GLITCH_W'(FILT_CYCLES - 1)) begin
        next_r.stable[i] = cmp.raw[i];
        next_r.cnt[i] = '0;
      end else begin
        next_r.cnt[i] = r.cnt[i] + SLM_GLITCH_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      r <= '{stable: 2'h3, cnt: '0};
    end else begin
      r <= next_r;
    end
  end

  assign cmp.clean = r.stable;

  a_short_glitch_blocked: assert property (@(posedge core_clk) disable iff (srst)
    $changed(r.stable[0]) |->
      (($past(cmp.raw[0]) == r.stable[0]) && ($past(cmp.raw[0], 2) == r.stable[0])))
    else $error("short glitch changed filtered analog level");

  a_digital_glitch_blocked: assert property (@(posedge core_clk) disable iff (srst)
    $changed(r.stable[1]) |->
      (($past(cmp.raw[1]) == r.stable[1]) && ($past(cmp.raw[1], 2) == r.stable[1])))
    else $error("short glitch changed filtered digital level");

endmodule : slm_glitch_filter

/* src/slm_supply_low_monitor.sv */
// Module: supply low monitor control register, flag and hold-off
`timescale 1ns/1ps
module slm_supply_low_monitor import slm_pkg::*; #(
  parameter longint HOLD_CYCLES = SLM_HOLD_CYCLES,
  parameter int FILT_CYCLES = SLM_GLITCH_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Special-function register access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Analog comparators
  input wire logic digital_supply_compare,
  input wire logic analog_supply_compare,
  output logic [1:0] digital_trip_select,
  output logic [1:0] analog_trip_select,
  output logic comparators_on,
  // Interrupt and watchdog
  input wire logic secondary_irq_enable_priority,
  output logic low_supply_irq,
  output logic watchdog_enable_clear
);

  ////////////////////////////////////////////////////////////////////////////////
  // Glitch filter
  slm_cmp_if cmp ();
  assign cmp.raw = {digital_supply_compare, analog_supply_compare};

  slm_glitch_filter #(.FILT_CYCLES(FILT_CYCLES)) u_filt (
    .core_clk(core_clk),
    .srst(srst),
    .cmp(cmp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // State
  slm_top_s r;
  slm_top_s next_r;
  logic any_low;
  logic ctrl_wr;
  logic [7:0] live_view;

  assign ctrl_wr = sfr_wr && (sfr_addr == SLM_CTRL_ADDR);
  assign any_low = r.on && (cmp.clean != 2'h3);

  always_comb begin
    next_r = r;
    live_view = {digital_supply_compare, analog_supply_compare, r.flag,
                 r.dtrip, r.atrip, r.on};
    if (ctrl_wr) begin
      next_r.dtrip = sfr_wdata[SLM_BIT_DTRIP_HI:SLM_BIT_DTRIP_LO];
      next_r.atrip = sfr_wdata[SLM_BIT_ATRIP_HI:SLM_BIT_ATRIP_LO];
      next_r.on = sfr_wdata[SLM_BIT_ON];
      next_r.flag = sfr_wdata[SLM_BIT_FLAG];
    end
    if (any_low) begin
      next_r.flag = 1'b1;
      next_r.hold = '0;
    end else if (r.flag) begin
      if (longint'(r.hold) >= HOLD_CYCLES - 1) begin
        next_r.hold = '0;
        if (!(ctrl_wr && sfr_wdata[SLM_BIT_FLAG])) begin
          next_r.flag = 1'b0;
        end
      end else begin
        next_r.hold = r.hold + SLM_HOLD_W'(1);
      end
    end else begin
      next_r.hold = '0;
    end
    if (sfr_rd && sfr_addr == SLM_CTRL_ADDR) begin
      next_r.rdata = live_view;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      r.dtrip <= SLM_CTRL_RESET[SLM_BIT_DTRIP_HI:SLM_BIT_DTRIP_LO];
      r.atrip <= SLM_CTRL_RESET[SLM_BIT_ATRIP_HI:SLM_BIT_ATRIP_LO];
      r.on <= SLM_CTRL_RESET[SLM_BIT_ON];
      r.flag <= SLM_CTRL_RESET[SLM_BIT_FLAG];
      r.hold <= '0;
      r.rdata <= SLM_CTRL_RESET;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign sfr_rdata = r.rdata;
  assign digital_trip_select = r.dtrip;
  assign analog_trip_select = r.atrip;
  assign comparators_on = r.on;
  assign low_supply_irq = r.flag && secondary_irq_enable_priority;
  assign watchdog_enable_clear = low_supply_irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_low_seen;
    any_low;
  endsequence

  a_flag_sets_low: assert property (@(posedge core_clk) disable iff (srst)
    s_low_seen |=> r.flag)
    else $error("flag not set while a supply is low");

  a_clear_refused_low: assert property (@(posedge core_clk) disable iff (srst)
    (any_low && ctrl_wr && !sfr_wdata[SLM_BIT_FLAG]) |=> r.flag)
    else $error("flag cleared while a supply is low");

  a_hold_restarts: assert property (@(posedge core_clk) disable iff (srst)
    s_low_seen |=> (r.hold == '0))
    else $error("hold-off not restarted");

  a_hold_counts: assert property (@(posedge core_clk) disable iff (srst)
    (r.flag && !any_low && !ctrl_wr && longint'(r.hold) < HOLD_CYCLES - 1)
      |=> (r.flag && r.hold == $past(r.hold) + SLM_HOLD_W'(1)))
    else $error("hold-off did not advance");

  a_disabled_quiet: assert property (@(posedge core_clk) disable iff (srst)
    (!r.on && !r.flag && !ctrl_wr) |=> !r.flag)
    else $error("flag raised while disabled");

  a_irq_gated: assert property (@(posedge core_clk) disable iff (srst)
    low_supply_irq |-> (r.flag && secondary_irq_enable_priority))
    else $error("interrupt without enable");

  a_wdog_cleared: assert property (@(posedge core_clk) disable iff (srst)
    (r.flag && secondary_irq_enable_priority) |-> watchdog_enable_clear)
    else $error("watchdog enable not cleared");

  a_trip_written: assert property (@(posedge core_clk) disable iff (srst)
    ctrl_wr |=> (digital_trip_select == $past(sfr_wdata[4:3])
      && analog_trip_select == $past(sfr_wdata[2:1])))
    else $error("trip select not written");

  a_status_live: assert property (@(posedge core_clk) disable iff (srst)
    (sfr_rd && sfr_addr == SLM_CTRL_ADDR) |=>
      (sfr_rdata[7:6] == $past({digital_supply_compare, analog_supply_compare})))
    else $error("comparator status bits not live");

endmodule : slm_supply_low_monitor

/* tb/slm_cmp_model.sv */
// Comparator model: supply levels against selected trip points
`timescale 1ns/1ps
module slm_cmp_model (
  // Supply levels in millivolts
  input wire logic [12:0] dsup_mv,
  input wire logic [12:0] asup_mv,
  // Trip selects
  input wire logic [1:0] dsel,
  input wire logic [1:0] asel,
  // Comparator levels
  output logic dcmp,
  output logic acmp
);
  function automatic logic [12:0] trip_mv(logic [1:0] s);
    trip_mv = s == 2'h0 ? 13'h1216 : s == 2'h1 ? 13'hc08 : s == 2'h2 ? 13'hb72 : 13'ha46;
  endfunction : trip_mv
  assign dcmp = dsup_mv > trip_mv(dsel);
  assign acmp = asup_mv > trip_mv(asel);
endmodule : slm_cmp_model

/* tb/tb.sv */
// Testbench: supply low monitor
`timescale 1ns/1ps
module tb import slm_pkg::*;;
  logic core_clk, srst, sfr_wr, sfr_rd, irq_en, dcmp, acmp, irq, wdc, on;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [1:0] dsel, asel;
  logic [12:0] dmv, amv, hi;
  int err_total, n_checks, seed, n;
  slm_supply_low_monitor #(.HOLD_CYCLES(20), .FILT_CYCLES(8)) slm_supply_low_monitor_inst (
    .core_clk(core_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .digital_supply_compare(dcmp), .analog_supply_compare(acmp),
    .digital_trip_select(dsel), .analog_trip_select(asel), .comparators_on(on),
    .secondary_irq_enable_priority(irq_en), .low_supply_irq(irq),
    .watchdog_enable_clear(wdc));
  slm_cmp_model slm_cmp_model_inst (.dsup_mv(dmv), .asup_mv(amv), .dsel(dsel),
    .asel(asel), .dcmp(dcmp), .acmp(acmp));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    sfr_wr = w;
    sfr_rd = !w;
    sfr_addr = a;
    sfr_wdata = d;
    cyc(1);
    sfr_wr = 0;
    sfr_rd = 0;
    cyc(2);
  endtask : acc
  function automatic logic up(logic [12:0] mv, logic [1:0] t);
    up = mv > (t == 2'h0 ? 13'h1216 : t == 2'h1 ? 13'hc08 : t == 2'h2 ? 13'hb72 : 13'ha46);
  endfunction : up
  function automatic logic [7:0] ev(logic [1:0] t, logic f, logic o);
    ev = {up(dmv, t), up(amv, t), f, t, t, o};
  endfunction : ev
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    wrap_up();
  end
  initial begin
    seed = 32'hc663;
    srst = 1;
    sfr_wr = 0;
    sfr_rd = 0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    irq_en = 1;
    dmv = 13'h1388;
    amv = 13'h1388;
    cyc(3);
    srst = 0;
    acc(0, SLM_CTRL_ADDR, 8'h00);
    chk("reset", sfr_rdata, SLM_CTRL_RESET);
    cyc(25);
    acc(0, SLM_CTRL_ADDR, 8'h00);
    chk("holdoff", sfr_rdata, ev(2'h3, 0, 0));
    $display("reset test done");
    dmv = 13'hbb8;
    amv = 13'hbb8;
    for (int t = 0; t < 4; t++) begin
      acc(1, SLM_CTRL_ADDR, {3'h0, 2'(t), 2'(t), 1'b0});
      acc(0, SLM_CTRL_ADDR, 8'h00);
      chk("trip", sfr_rdata, ev(2'(t), 0, 0));
      chk("sel", {4'h0, dsel, asel}, {4'h0, 2'(t), 2'(t)});
      chk("off", {7'h0, on}, 8'h00);
    end
    $display("trip test done");
    hi = 13'h1300 + 13'($random(seed) & 32'h3f);
    dmv = hi;
    amv = hi;
    acc(1, SLM_CTRL_ADDR, 8'h1f);
    chk("on", {7'h0, on}, 8'h01);
    dmv = 13'h9c4;
    cyc(5);
    dmv = hi;
    cyc(12);
    chk("glitch", {7'h0, irq}, 8'h00);
    n = 10 + ($random(seed) & 31);
    amv = 13'h9c4;
    cyc(n);
    chk("irq", {6'h0, irq, wdc}, 8'h03);
    acc(1, SLM_CTRL_ADDR, 8'h1f);
    acc(0, SLM_CTRL_ADDR, 8'h00);
    chk("noclear", sfr_rdata, ev(2'h3, 1, 1));
    amv = hi;
    cyc(18);
    amv = 13'h9c4;
    cyc(10);
    amv = hi;
    cyc(23);
    chk("restart", {7'h0, irq}, 8'h01);
    cyc(10);
    chk("cleared", {7'h0, irq}, 8'h00);
    $display("flag test done");
    acc(1, SLM_CTRL_ADDR, 8'h3f);
    irq_en = 0;
    cyc(1);
    chk("masked", {7'h0, irq}, 8'h00);
    irq_en = 1;
    cyc(1);
    chk("swset", {6'h0, irq, wdc}, 8'h03);
    acc(1, SLM_CTRL_ADDR, 8'h1f);
    acc(0, SLM_CTRL_ADDR, 8'h00);
    chk("swclear", sfr_rdata, ev(2'h3, 0, 1));
    acc(1, 8'hde, 8'h00);
    acc(0, 8'hde, 8'h00);
    chk("unmapped", sfr_rdata, ev(2'h3, 0, 1));
    $display("software test done");
    acc(1, SLM_CTRL_ADDR, 8'h3f);
    srst = 1;
    cyc(2);
    srst = 0;
    acc(0, SLM_CTRL_ADDR, 8'h00);
    chk("rereset", sfr_rdata, SLM_CTRL_RESET);
    chk("rereset on", {6'h0, on, irq}, 8'h00);
    $display("reset again test done");
    wrap_up();
  end
endmodule : tb
